// ### logic/pmia_consts.vh
// Purpose: Shared constants for the PHY management indirect access block.
// Assumes: Byte addresses on a 32-bit AHB-Lite register bus.
// Notes: Definitions only; included by bare name.
`ifndef PMIA_CONSTS_VH
`define PMIA_CONSTS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define PMIA_OFS_DATA 32'h000000A4
`define PMIA_OFS_ACCESS 32'h000000A8
`define PMIA_OFS_V_CTRL 32'h000001C0
`define PMIA_OFS_V_STATUS 32'h000001C4
`define PMIA_OFS_V_ID_UP 32'h000001C8
`define PMIA_OFS_V_ID_LO 32'h000001CC
`define PMIA_OFS_V_ADV 32'h000001D0
`define PMIA_OFS_V_PARTNER 32'h000001D4
`define PMIA_OFS_V_EXP 32'h000001D8
`define PMIA_OFS_V_SPECIAL 32'h000001DC

// ----------------------------------------------------------------------
// Access control field positions
// ----------------------------------------------------------------------
`define PMIA_PHY_HI 15
`define PMIA_PHY_LO 11
`define PMIA_IDX_HI 10
`define PMIA_IDX_LO 6
`define PMIA_WNR_BIT 1
`define PMIA_BUSY_BIT 0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PMIA_RST_FIELD5 5'h00
`define PMIA_RST_WNR 1'b0
`define PMIA_RST_DATA 16'h0000
`define PMIA_RST_V_CTRL 16'h1000
`define PMIA_RST_V_OTHER 16'h0000

// ----------------------------------------------------------------------
// Serial management frame
// ----------------------------------------------------------------------
`define PMIA_PREAMBLE 6'h20
`define PMIA_ST 2'h1
`define PMIA_OP_RD 2'h2
`define PMIA_OP_WR 2'h1
`define PMIA_HDR_LAST 5'h0D
`define PMIA_DATA_LAST 5'h0F
`define PMIA_IDX_SPECIAL 5'h1F
`define PMIA_SLOT_ID_UP 3'h2
`define PMIA_SLOT_ID_LO 3'h3
`define PMIA_SLOT_SPECIAL 3'h7

`endif

// ### logic/pmia_top.v
// Purpose: Indirect PHY register access over AHB-Lite plus an emulated
//          single-port PHY served on the serial management pins.
// Assumes: Internal PHYs answer on a same-clock request/done port.
// Notes: Read transfers take one wait state; writes take none.
//
// Behaviour
// - Every write to the access control register launches one internal PHY cycle.
// - Target PHY number comes from access bits 15:11, reset zero.
// - Target register index comes from access bits 10:6, reset zero.
// - Select bit 1 set makes the cycle write the held data value.
// - Select bit clear makes the cycle read into the data register.
// - Busy bit 0 sets on any access write and holds during the cycle.
// - Busy clears itself when the internal PHY reports completion.
// - Indirect path reaches only internal PHYs, never the emulated PHY.
// - Emulated PHY registers are also reachable through the memory map.
// - Serial management is served only while the PHY mode input is high.
// - Emulated PHY answers only frames addressed to the strapped address.
// - Each serial register transfer carries exactly 16 data bits.
// - Serial indices 0 to 6 and 31 select the emulated registers.
// - Data register holds 16 bits: write data out, read data in.
// - Data reads give PHY value if select is 0, last written if 1.
`include "pmia_consts.vh"

module pmia_top #(
    parameter [15:0] ID_UPPER = 16'h0123,
    parameter [15:0] ID_LOWER = 16'h4567
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    output reg phy_req,
    output reg [4:0] phy_req_addr,
    output reg [4:0] phy_req_index,
    output reg phy_req_write,
    output reg [15:0] phy_req_wdata,
    input wire phy_done,
    input wire [15:0] phy_rdata,
    input wire phy_mode,
    input wire [4:0] phy_addr_strap,
    input wire mdc,
    input wire mdio_in,
    output reg mdio_out,
    output reg mdio_oe_n
);
    // ID_UPPER and ID_LOWER are arbitrary identity values.

    localparam M_PRE = 4'b0001;
    localparam M_HDR = 4'b0010;
    localparam M_TA = 4'b0100;
    localparam M_DATA = 4'b1000;

    // ------------------------------------------------------------------
    // Synchronisers and strap capture
    // ------------------------------------------------------------------
    reg mdc_s1, mdc_s2, mdc_d;
    reg mdio_s1, mdio_s2;
    reg mode_s1, mode_s2;
    reg [4:0] strap_s1, strap_s2, strap_addr;
    reg [1:0] strap_cnt;
    wire mdc_rise;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mdc_s1 <= 1'b0;
            mdc_s2 <= 1'b0;
            mdc_d <= 1'b0;
            mdio_s1 <= 1'b1;
            mdio_s2 <= 1'b1;
            mode_s1 <= 1'b0;
            mode_s2 <= 1'b0;
            strap_s1 <= 5'h00;
            strap_s2 <= 5'h00;
            strap_addr <= 5'h00;
            strap_cnt <= 2'h0;
        end else begin
            mdc_s1 <= mdc;
            mdc_s2 <= mdc_s1;
            mdc_d <= mdc_s2;
            mdio_s1 <= mdio_in;
            mdio_s2 <= mdio_s1;
            mode_s1 <= phy_mode;
            mode_s2 <= mode_s1;
            strap_s1 <= phy_addr_strap;
            strap_s2 <= strap_s1;
            // The strap is loaded on the first three cycles and then held; the third load takes it after it has crossed the chain.
            if (strap_cnt != 2'h3) begin
                strap_cnt <= strap_cnt + 2'h1;
                strap_addr <= strap_s2;
            end
        end
    end

    assign mdc_rise = mdc_s2 & ~mdc_d;

    // ------------------------------------------------------------------
    // Emulated PHY storage
    // ------------------------------------------------------------------
    reg [15:0] vreg [0:7];
    reg m_wr_go;
    reg [2:0] m_slot;
    reg [15:0] m_wdata;
    reg a_vwr;
    reg [2:0] a_vslot;

    function [3:0] pmia_smap;
        input [4:0] idx;
        begin
            if (idx <= 5'h06) begin
                pmia_smap = {1'b1, idx[2:0]};
            end else if (idx == `PMIA_IDX_SPECIAL) begin
                pmia_smap = {1'b1, `PMIA_SLOT_SPECIAL};
            end else begin
                pmia_smap = 4'h0;
            end
        end
    endfunction

    function [15:0] pmia_vread;
        input [2:0] slot;
        begin
            case (slot)
                `PMIA_SLOT_ID_UP: pmia_vread = ID_UPPER;
                `PMIA_SLOT_ID_LO: pmia_vread = ID_LOWER;
                default: pmia_vread = vreg[slot];
            endcase
        end
    endfunction

    integer i;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (i = 0; i < 8; i = i + 1) begin
                vreg[i] <= `PMIA_RST_V_OTHER;
            end
            vreg[0] <= `PMIA_RST_V_CTRL;
        end else begin
            // Identity words are read-only; a bus write in the same cycle
            // as a serial write wins because it is applied last.
            if (m_wr_go && m_slot != `PMIA_SLOT_ID_UP && m_slot != `PMIA_SLOT_ID_LO) begin
                vreg[m_slot] <= m_wdata;
            end
            if (a_vwr && a_vslot != `PMIA_SLOT_ID_UP && a_vslot != `PMIA_SLOT_ID_LO) begin
                vreg[a_vslot] <= hwdata[15:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------------
    reg dp_write, dp_read;
    reg [31:0] dp_addr;
    reg [15:0] data_wr, data_rd;
    reg busy;
    reg [3:0] a_map;
    reg [31:0] rd_mux;
    wire addr_take;

    assign addr_take = hsel & htrans[1] & hready;
    assign hreadyout = ~dp_read;
    assign hresp = 1'b0;

    always @* begin
        a_map = 4'h0;
        case (dp_addr)
            `PMIA_OFS_V_CTRL: a_map = 4'h8;
            `PMIA_OFS_V_STATUS: a_map = 4'h9;
            `PMIA_OFS_V_ID_UP: a_map = 4'hA;
            `PMIA_OFS_V_ID_LO: a_map = 4'hB;
            `PMIA_OFS_V_ADV: a_map = 4'hC;
            `PMIA_OFS_V_PARTNER: a_map = 4'hD;
            `PMIA_OFS_V_EXP: a_map = 4'hE;
            `PMIA_OFS_V_SPECIAL: a_map = 4'hF;
            default: a_map = 4'h0;
        endcase
    end

    always @* begin
        rd_mux = 32'h00000000;
        if (dp_addr == `PMIA_OFS_DATA) begin
            rd_mux[15:0] = phy_req_write ? data_wr : data_rd;
        end else if (dp_addr == `PMIA_OFS_ACCESS) begin
            rd_mux[`PMIA_PHY_HI:`PMIA_PHY_LO] = phy_req_addr;
            rd_mux[`PMIA_IDX_HI:`PMIA_IDX_LO] = phy_req_index;
            rd_mux[`PMIA_WNR_BIT] = phy_req_write;
            rd_mux[`PMIA_BUSY_BIT] = busy;
        end
    end

    always @* begin
        a_vwr = dp_write & a_map[3];
        a_vslot = a_map[2:0];
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_read <= 1'b0;
            dp_addr <= 32'h00000000;
            hrdata <= 32'h00000000;
        end else begin
            dp_write <= 1'b0;
            dp_read <= 1'b0;
            if (dp_read) begin
                // The wait state lets a preceding write land before the read.
                // Emulated words are read at the edge: a combinational mux
                // would miss a change inside the array at an unchanged address.
                hrdata <= a_map[3] ? {16'h0000, pmia_vread(a_map[2:0])} : rd_mux;
            end else if (addr_take) begin
                dp_addr <= {haddr[31:2], 2'b00};
                dp_write <= hwrite;
                dp_read <= ~hwrite;
            end
        end
    end

    // ------------------------------------------------------------------
    // Indirect access to the internal PHYs
    // ------------------------------------------------------------------
    wire acc_wr;
    wire data_wr_en;

    assign acc_wr = dp_write & (dp_addr == `PMIA_OFS_ACCESS);
    assign data_wr_en = dp_write & (dp_addr == `PMIA_OFS_DATA);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phy_req <= 1'b0;
            phy_req_addr <= `PMIA_RST_FIELD5;
            phy_req_index <= `PMIA_RST_FIELD5;
            phy_req_write <= `PMIA_RST_WNR;
            phy_req_wdata <= `PMIA_RST_DATA;
            data_wr <= `PMIA_RST_DATA;
            data_rd <= `PMIA_RST_DATA;
            busy <= 1'b0;
        end else begin
            phy_req <= acc_wr;
            if (acc_wr) begin
                phy_req_addr <= hwdata[`PMIA_PHY_HI:`PMIA_PHY_LO];
                phy_req_index <= hwdata[`PMIA_IDX_HI:`PMIA_IDX_LO];
                phy_req_write <= hwdata[`PMIA_WNR_BIT];
                phy_req_wdata <= data_wr;
            end
            if (data_wr_en) begin
                data_wr <= hwdata[15:0];
            end
            // A completion never overrides a fresh launch in the same cycle.
            if (acc_wr) begin
                busy <= 1'b1;
            end else if (phy_done) begin
                busy <= 1'b0;
            end
            if (phy_done && busy && !phy_req_write) begin
                data_rd <= phy_rdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Serial management slave for the emulated PHY
    // ------------------------------------------------------------------
    reg [3:0] mstate;
    reg [5:0] ones;
    reg [4:0] bitcnt;
    reg [13:0] hdr;
    reg is_rd, is_wr, slot_ok;
    reg [15:0] shreg;
    wire [13:0] hdr_full;
    wire [3:0] hdr_map;
    wire hdr_match;

    assign hdr_full = {hdr[12:0], mdio_s2};
    assign hdr_map = pmia_smap(hdr_full[4:0]);
    assign hdr_match = (hdr_full[13:12] == `PMIA_ST) && (hdr_full[9:5] == strap_addr);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mstate <= M_PRE;
            ones <= 6'h00;
            bitcnt <= 5'h00;
            hdr <= 14'h0000;
            is_rd <= 1'b0;
            is_wr <= 1'b0;
            slot_ok <= 1'b0;
            shreg <= 16'h0000;
            m_slot <= 3'h0;
            m_wdata <= 16'h0000;
            m_wr_go <= 1'b0;
            mdio_out <= 1'b0;
            mdio_oe_n <= 1'b1;
        end else begin
            m_wr_go <= 1'b0;
            if (!mode_s2) begin
                mstate <= M_PRE;
                ones <= 6'h00;
                mdio_oe_n <= 1'b1;
                mdio_out <= 1'b0;
            end else if (mdc_rise) begin
                case (mstate)
                    M_PRE: begin
                        if (mdio_s2) begin
                            if (ones != `PMIA_PREAMBLE) begin
                                ones <= ones + 6'h01;
                            end
                        end else begin
                            if (ones == `PMIA_PREAMBLE) begin
                                mstate <= M_HDR;
                                hdr <= 14'h0000;
                                bitcnt <= 5'h01;
                            end
                            ones <= 6'h00;
                        end
                    end
                    M_HDR: begin
                        hdr <= hdr_full;
                        bitcnt <= bitcnt + 5'h01;
                        if (bitcnt == `PMIA_HDR_LAST) begin
                            bitcnt <= 5'h00;
                            is_rd <= hdr_full[11:10] == `PMIA_OP_RD;
                            is_wr <= hdr_full[11:10] == `PMIA_OP_WR;
                            slot_ok <= hdr_map[3];
                            m_slot <= hdr_map[2:0];
                            shreg <= hdr_map[3] ? pmia_vread(hdr_map[2:0]) : 16'h0000;
                            if (hdr_match && (hdr_full[11:10] == `PMIA_OP_RD
                                    || hdr_full[11:10] == `PMIA_OP_WR)) begin
                                mstate <= M_TA;
                            end else begin
                                mstate <= M_PRE;
                            end
                        end
                    end
                    M_TA: begin
                        bitcnt <= bitcnt + 5'h01;
                        if (bitcnt == 5'h00) begin
                            if (is_rd) begin
                                mdio_oe_n <= 1'b0;
                                mdio_out <= 1'b0;
                            end
                        end else begin
                            mstate <= M_DATA;
                            bitcnt <= 5'h00;
                            if (is_rd) begin
                                mdio_out <= shreg[15];
                                shreg <= {shreg[14:0], 1'b0};
                            end
                        end
                    end
                    M_DATA: begin
                        bitcnt <= bitcnt + 5'h01;
                        if (is_wr) begin
                            shreg <= {shreg[14:0], mdio_s2};
                        end else begin
                            mdio_out <= shreg[15];
                            shreg <= {shreg[14:0], 1'b0};
                        end
                        if (bitcnt == `PMIA_DATA_LAST) begin
                            mstate <= M_PRE;
                            ones <= 6'h00;
                            mdio_oe_n <= 1'b1;
                            mdio_out <= 1'b0;
                            m_wdata <= {shreg[14:0], mdio_s2};
                            m_wr_go <= is_wr & slot_ok;
                        end
                    end
                    default: begin
                        mstate <= M_PRE;
                        ones <= 6'h00;
                    end
                endcase
            end
        end
    end
endmodule

// ### tb/pmia_props.sv
// Purpose: Port-level checks for pmia_top.
// Assumes: The link clock period is MDC_CYC hclk cycles.
// Notes: Bound to every pmia_top instance.
`include "pmia_consts.vh"
module pmia_props #(
    parameter int MDC_CYC = 32
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic phy_req,
    input wire logic [4:0] phy_req_addr,
    input wire logic [4:0] phy_req_index,
    input wire logic phy_req_write,
    input wire logic phy_mode,
    input wire logic mdio_out,
    input wire logic mdio_oe_n
);
    // A read answer is the turnaround bit plus 16 data bits; allow sync jitter.
    localparam int LO_MIN = 17 * MDC_CYC - 4;
    localparam int LO_MAX = 17 * MDC_CYC + 4;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic wr_acc;
    logic [4:0] wd_phy;
    logic [4:0] wd_idx;
    logic wd_wnr;
    logic [11:0] low_cnt;
    assign wr_acc = hsel && htrans[1] && hready && hwrite && haddr == `PMIA_OFS_ACCESS;
    assign wd_phy = hwdata[15:11];
    assign wd_idx = hwdata[10:6];
    assign wd_wnr = hwdata[1];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_cnt <= 12'h000;
        end else if (mdio_oe_n) begin
            low_cnt <= 12'h000;
        end else begin
            low_cnt <= low_cnt + 12'h001;
        end
    end
    req_launch_a: assert property (wr_acc |-> ##2 phy_req)
        else $error("no launch after access write");
    req_cause_a: assert property (phy_req |-> $past(wr_acc, 2))
        else $error("launch without access write");
    target_fields_a: assert property (phy_req |->
        phy_req_addr == $past(wd_phy) && phy_req_index == $past(wd_idx))
        else $error("launch fields differ from written value");
    write_sel_a: assert property (phy_req |-> phy_req_write == $past(wd_wnr))
        else $error("launch direction differs from select bit");
    fields_hold_a: assert property (!phy_req |->
        $stable(phy_req_index) && $stable(phy_req_addr))
        else $error("launch fields moved without a launch");
    mode_gate_a: assert property ((!phy_mode) [*6] |-> mdio_oe_n)
        else $error("serial pin driven outside phy mode");
    ta_zero_a: assert property ($fell(mdio_oe_n) |-> !mdio_out)
        else $error("turnaround not driven low");
    data_bits_a: assert property ($rose(mdio_oe_n) |->
        low_cnt >= LO_MIN && low_cnt <= LO_MAX)
        else $error("serial answer length wrong");
    read_wait_a: assert property ((hsel && htrans[1] && hready && !hwrite) |=>
        !hreadyout ##1 (hreadyout && hrdata[31:16] == 16'h0000))
        else $error("read answer timing or upper bits wrong");
endmodule
bind pmia_top pmia_props #(.MDC_CYC(32)) u_props (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .phy_req(phy_req),
    .phy_req_addr(phy_req_addr), .phy_req_index(phy_req_index),
    .phy_req_write(phy_req_write), .phy_mode(phy_mode), .mdio_out(mdio_out),
    .mdio_oe_n(mdio_oe_n));

// ### tb/pmia_mdio_master.sv
// Purpose: Serial management master facing the emulated PHY.
// Assumes: 160 ns link clock, pulled-up data line.
// Notes: The link clock stands still low between frames.
module pmia_mdio_master (
    output logic mdc,
    output logic drv_en,
    output logic drv_val,
    input wire logic line
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        mdc = 1'b0;
        drv_en = 1'b0;
        drv_val = 1'b1;
    end
    task automatic bit_cyc(input logic b, output logic s);
        drv_val = b;
        #80;
        s = line;
        mdc = 1'b1;
        #80;
        mdc = 1'b0;
    endtask
    // Returns the turnaround bit and 16 data bits, most significant first.
    task automatic frame(input logic rd_op, input logic [4:0] pa, input logic [4:0] ra,
            input logic [15:0] wd, output logic [16:0] q);
        logic [31:0] frm;
        logic s;
        frm = {2'b01, rd_op, !rd_op, pa, ra, 2'b10, wd};
        q = 17'h1FFFF;
        #1;
        drv_en = 1'b1;
        repeat (32) bit_cyc(1'b1, s);
        for (int i = 31; i >= 0; i--) begin
            drv_en = !(rd_op && i < 18);
            bit_cyc(frm[i], s);
            q = {q[15:0], s};
        end
        drv_en = 1'b0;
        #400;
    endtask
endmodule

// ### tb/phy_mgmt_indirect_access_tb_top.sv
// Purpose: Self-checking bench for pmia_top.
// Assumes: Internal PHYs answer 21 cycles after a launch.
// Notes: Identity values are arbitrary.
`include "pmia_consts.vh"
module phy_mgmt_indirect_access_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] ID_UP = 16'hA5C3;
    localparam logic [15:0] ID_LO = 16'h3C5A;
    localparam logic [4:0] STRAP = 5'h0B;
    localparam logic [31:0] A_DAT = `PMIA_OFS_DATA;
    localparam logic [31:0] A_ACC = `PMIA_OFS_ACCESS;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, phy_done = 0, phy_mode = 1;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rv;
    logic [1:0] htrans = 0;
    logic [15:0] phy_rdata = 0, seen_wd;
    logic [4:0] seen_addr, seen_idx;
    logic [4:0] phy_addr_strap = STRAP;
    logic hreadyout, phy_req, phy_req_write, mdc, m_en, m_val, mdio_out, mdio_oe_n, seen_wr;
    logic [4:0] phy_req_addr, phy_req_index;
    logic [15:0] phy_req_wdata;
    logic [16:0] q;
    logic hresp;
    int errors = 0, compares = 0, dly = 0, cyc = 0;
    wire mdio_line = !mdio_oe_n ? mdio_out : (m_en ? m_val : 1'b1);
    always #2.5 hclk = ~hclk;
    pmia_top #(.ID_UPPER(ID_UP), .ID_LOWER(ID_LO)) u_dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .phy_req(phy_req), .phy_req_addr(phy_req_addr),
        .phy_req_index(phy_req_index), .phy_req_write(phy_req_write),
        .phy_req_wdata(phy_req_wdata), .phy_done(phy_done), .phy_rdata(phy_rdata),
        .phy_mode(phy_mode), .phy_addr_strap(phy_addr_strap), .mdc(mdc),
        .mdio_in(mdio_line), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n));
    pmia_mdio_master u_mdm (.mdc(mdc), .drv_en(m_en), .drv_val(m_val), .line(mdio_line));
    // Internal PHY: read data is only valid in the completion cycle.
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        phy_done <= 1'b0;
        phy_rdata <= (dly == 1) ? 16'h5A17 : 16'hA5E8;
        if (phy_req) begin
            {seen_addr, seen_idx, seen_wr, seen_wd} <= {phy_req_addr, phy_req_index,
                phy_req_write, phy_req_wdata};
            dly <= 20;
        end else if (dly > 0) begin
            dly <= dly - 1;
            phy_done <= (dly == 1);
        end
        if (cyc == 90000) begin
            errors++;
            summarize();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wait_rdy();
        logic r;
        do begin
            @(negedge hclk);
            r = hreadyout;
            rv = hrdata;
            @(posedge hclk);
        end while (r !== 1'b1);
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        hsel <= 1'b0;
    endtask
    task automatic wait_busy();
        int n;
        n = 0;
        do begin
            ahb(0, A_ACC, 0);
            n++;
        end while (rv[0] !== 1'b0 && n < 100);
        chk("busy", 0, {31'h0, rv[0]});
    endtask
    task automatic t_reset_vals();
        ahb(0, A_ACC, 0); chk("access reset", 0, rv);
        ahb(0, A_DAT, 0); chk("data reset", 0, rv);
        ahb(0, `PMIA_OFS_V_CTRL, 0); chk("ctrl reset", 32'h1000, rv);
        ahb(0, 32'h000001E0, 0); chk("unmapped", 0, rv);
        chk("okay", 0, {31'h0, hresp});
    endtask
    task automatic t_ind_write();
        ahb(1, A_DAT, 32'h0000BEEF);
        ahb(1, A_ACC, 32'h00001A42);
        ahb(0, A_ACC, 0); chk("busy set", 32'h00001A43, rv);
        wait_busy();
        chk("phy", 3, seen_addr);
        chk("index", 9, seen_idx);
        chk("wdata", {16'h8000, 16'hBEEF}, {seen_wr, 15'h0, seen_wd});
        ahb(0, A_DAT, 0); chk("data kept", 32'h0000BEEF, rv);
    endtask
    task automatic t_ind_read();
        ahb(1, A_ACC, {16'h0, STRAP, 11'h000});
        ahb(0, A_ACC, 0); chk("busy read", 32'h00005801, rv);
        wait_busy();
        chk("dir", 0, seen_wr);
        ahb(0, A_DAT, 0); chk("read data", 32'h00005A17, rv);
    endtask
    task automatic t_serial_map();
        logic [31:0] a;
        logic [4:0] ix;
        logic [15:0] p, e;
        for (int k = 0; k < 8; k++) begin
            a = (k < 7) ? 32'h1C0 + 4 * k : 32'h1DC;
            ix = (k < 7) ? k[4:0] : 5'h1F;
            p = 16'hC300 | k[15:0];
            e = (k == 2) ? ID_UP : (k == 3) ? ID_LO : p;
            ahb(1, a, {16'h0, p});
            u_mdm.frame(1, STRAP, ix, 0, q);
            chk("serial read", {15'h0, 1'b0, e}, {15'h0, q});
            u_mdm.frame(0, STRAP, ix, ~p, q);
            e = (k == 2) ? ID_UP : (k == 3) ? ID_LO : ~p;
            ahb(0, a, 0); chk("serial write", {16'h0, e}, rv);
        end
    endtask
    task automatic t_serial_refuse();
        u_mdm.frame(0, STRAP, 5'h09, 16'hFFFF, q);
        u_mdm.frame(1, STRAP, 5'h09, 0, q);
        chk("undecoded", 0, {15'h0, q});
        u_mdm.frame(1, STRAP ^ 5'h01, 5'h00, 0, q);
        chk("other addr", 32'h1FFFF, {15'h0, q});
        @(posedge hclk) phy_mode <= 1'b0;
        repeat (10) @(posedge hclk);
        u_mdm.frame(1, STRAP, 5'h00, 0, q);
        chk("mode off", 32'h1FFFF, {15'h0, q});
        @(posedge hclk) phy_mode <= 1'b1;
        repeat (10) @(posedge hclk);
    endtask
    task automatic summarize();
        if (errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset_vals();
        t_ind_write();
        t_ind_read();
        t_serial_map();
        t_serial_refuse();
        summarize();
    end
endmodule
